// File: sfesp_core.sv
// serial flash erase, pause/resume and deep sleep sequencer with id reads
`timescale 1ns/1ps
`default_nettype none

module sfesp_core #(
    parameter int ERASE_BLK_CYCLES = sfesp_pkg::ERASE_BLK_CYC,
    parameter int ERASE_ALL_CYCLES = sfesp_pkg::ERASE_ALL_CYC,
    parameter logic [7:0] MFR_ID = 8'ha5, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h3c  // arbitrary value
) (
    // core clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // serial link
    input wire logic link_clk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_i,
    output logic so_o,
    output logic so_oe_n_o,
    // protection settings
    input wire logic complement_protect_i,
    input wire logic small_unit_protect_i,
    input wire logic top_bottom_select_i,
    input wire logic [2:0] block_protect_field_i,
    // status
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic paused_flag_o,
    output logic sleeping_o,
    // array erase control
    output logic erase_chip_o,
    output logic [3:0] erase_block_o,
    output logic erase_done_o
);
    import sfesp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: capture on rising clock

    typedef struct packed {
        logic [5:0] cnt;
        logic ovf;
        logic [31:0] sh;
        logic [7:0] op;
        logic [23:0] addr;
        logic tog;
        logic [3:0] st_m;
        logic [3:0] st_s;
    } sfesp_link_t;

    sfesp_link_t lk, next_lk;
    logic fresh;
    logic [3:0] st_core;
    logic [5:0] cnt_inc;

    // fresh marks a frame whose first edge has not come yet
    always_ff @(posedge link_clk_i or posedge cs_n_i or posedge rst_i) begin
        if (cs_n_i || rst_i) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    assign cnt_inc = lk.cnt + 6'h01;

    always_comb begin
        next_lk = lk;
        next_lk.st_m = st_core;
        next_lk.st_s = lk.st_m;
        if (fresh) begin
            next_lk.cnt = 6'h01;
            next_lk.ovf = 1'b0;
            next_lk.sh = {31'h00000000, serial_in_i};
            next_lk.tog = ~lk.tog;
        end else begin
            next_lk.sh = {lk.sh[30:0], serial_in_i};
            // wrap keeps the id streams aligned to bytes forever
            if (lk.cnt == BITS_WRAP_TOP) begin
                next_lk.cnt = BITS_ADDR_END;
                next_lk.ovf = 1'b1;
            end else begin
                next_lk.cnt = cnt_inc;
            end
            if (lk.cnt == {1'b0, OP_LAST_CNT}) begin
                next_lk.op = {lk.sh[6:0], serial_in_i};
            end
            if (lk.cnt == ADDR_LAST_CNT && !lk.ovf) begin
                next_lk.addr = {lk.sh[22:0], serial_in_i};
            end
        end
    end

    // without a known start the frame toggle never settles and no frame decodes;
    // the link clock is idle while reset stands, so releasing it here is safe
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: drive out on falling clock

    logic l_busy, l_sleep;
    logic [7:0] tx_byte;
    logic tx_on;

    assign l_busy = lk.st_s[0];
    assign l_sleep = lk.st_s[3];

    always_comb begin
        tx_byte = 8'h00;
        tx_on = 1'b0;
        if (lk.op == OP_RD_STATUS && lk.cnt >= BITS_OPCODE && !l_sleep) begin
            tx_byte = 8'h00;
            tx_byte[ST_BUSY] = lk.st_s[0];
            tx_byte[ST_WEL] = lk.st_s[1];
            tx_byte[ST_SUS] = lk.st_s[2];
            tx_on = 1'b1;
        end else if (lk.op == OP_WAKE_ID && lk.cnt >= BITS_ADDR_END && !l_busy) begin
            tx_byte = DEV_ID;
            tx_on = 1'b1;
        end else if (lk.op == OP_MFR_DEV_ID && lk.cnt >= BITS_ADDR_END && !l_sleep
                     && lk.addr == ID_ADDR) begin
            tx_byte = lk.cnt[3] ? DEV_ID : MFR_ID;
            tx_on = 1'b1;
        end
    end

    // msb first, released at once when select rises
    always_ff @(negedge link_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else begin
            so_o <= tx_byte[3'h7 - lk.cnt[2:0]];
            so_oe_n_o <= ~tx_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain

    typedef struct packed {
        sfesp_state_t st;
        logic write_enable_latch;
        logic busy;
        logic paused_flag;
        logic sleep;
        logic chip;
        logic [3:0] blk;
        logic done;
        logic [31:0] tmr;
        logic [31:0] aux;
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic tog_m;
        logic tog_s;
        logic tog_seen;
    } sfesp_core_t;

    sfesp_core_t cr, next_cr;
    logic frame_end;
    logic [3:0] tgt;
    logic [4:0] n_prot;
    logic raw_hit, raw_full, blk_prot, chip_prot;
    logic is_erase_op, is_prog_op, op_ok, addr_ok;

    assign st_core = {cr.sleep, cr.paused_flag, cr.write_enable_latch, cr.busy};

    // frame words are read only after select is seen high, when they stand still
    assign frame_end = cr.cs_s && !cr.cs_p && (cr.tog_s != cr.tog_seen);
    assign op_ok = lk.cnt == BITS_OPCODE && !lk.ovf;
    assign addr_ok = lk.cnt == BITS_ADDR_END && !lk.ovf;
    assign tgt = lk.addr[BLK_MSB:BLK_LSB];

    // protected block count in 64 KB units, all blocks from the top codes
    assign n_prot = (block_protect_field_i >= BP_ALL_FROM) ? BLK_COUNT :
        5'(5'h01 << (block_protect_field_i - 3'h1));

    always_comb begin
        raw_hit = 1'b0;
        raw_full = 1'b0;
        if (block_protect_field_i != BP_NONE) begin
            if (small_unit_protect_i) begin
                raw_hit = top_bottom_select_i ? (tgt == BLK_BOTTOM) : (tgt == BLK_TOP);
            end else if (top_bottom_select_i) begin
                raw_hit = {1'b0, tgt} < n_prot;
                raw_full = raw_hit;
            end else begin
                raw_hit = {1'b0, tgt} >= BLK_COUNT - n_prot;
                raw_full = raw_hit;
            end
        end
        // complement: any page not in the plain region is protected
        blk_prot = complement_protect_i ? !raw_full : raw_hit;
    end

    // whole array is clean only if nothing at all is covered
    assign chip_prot = complement_protect_i ?
        !(!small_unit_protect_i && block_protect_field_i >= BP_ALL_FROM) :
        (block_protect_field_i != BP_NONE);

    assign is_erase_op = lk.op == OP_SECT_ERASE || lk.op == OP_HALF_ERASE
        || lk.op == OP_BLOCK_ERASE || lk.op == OP_CHIP_ERASE_A
        || lk.op == OP_CHIP_ERASE_B || lk.op == OP_SECR_ERASE;
    assign is_prog_op = lk.op == OP_PAGE_PROG || lk.op == OP_QUAD_PROG
        || lk.op == OP_SECR_PROG;

    always_comb begin
        next_cr = cr;
        next_cr.cs_m = cs_n_i;
        next_cr.cs_s = cr.cs_m;
        next_cr.cs_p = cr.cs_s;
        next_cr.tog_m = lk.tog;
        next_cr.tog_s = cr.tog_m;
        next_cr.done = 1'b0;
        if (frame_end) begin
            next_cr.tog_seen = cr.tog_s;
        end
        unique case (cr.st)
            SFESP_ERASE: begin
                if (cr.tmr <= 32'h1) begin
                    next_cr.st = SFESP_IDLE;
                    next_cr.busy = 1'b0;
                    next_cr.write_enable_latch = 1'b0;
                    next_cr.chip = 1'b0;
                    next_cr.done = 1'b1;
                    next_cr.tmr = 32'h0;
                end else begin
                    next_cr.tmr = cr.tmr - 32'h1;
                end
                // only the block erase may pause, never the whole array
                if (frame_end && op_ok && lk.op == OP_PAUSE && !cr.paused_flag && !cr.chip
                    && cr.tmr > 32'h1) begin
                    next_cr.st = SFESP_PAUSING;
                    next_cr.paused_flag = 1'b1;
                    next_cr.aux = 32'(PAUSE_CYC);
                end
            end
            SFESP_PAUSING: begin
                // array work is frozen; busy holds out the latency
                if (cr.aux <= 32'h1) begin
                    next_cr.st = SFESP_PAUSED;
                    next_cr.busy = 1'b0;
                end else begin
                    next_cr.aux = cr.aux - 32'h1;
                end
            end
            SFESP_PAUSED: begin
                if (frame_end && op_ok && lk.op == OP_RESUME) begin
                    next_cr.st = SFESP_ERASE;
                    next_cr.paused_flag = 1'b0;
                    next_cr.busy = 1'b1;
                end else if (frame_end && op_ok && lk.op == OP_WR_ENABLE) begin
                    next_cr.write_enable_latch = 1'b1;
                end else if (frame_end && op_ok && lk.op == OP_WR_DISABLE) begin
                    next_cr.write_enable_latch = 1'b0;
                end
                // status writes, erases and programs are simply dropped here
            end
            SFESP_ENTERING: begin
                if (cr.aux <= 32'h1) begin
                    next_cr.st = SFESP_ASLEEP;
                    next_cr.sleep = 1'b1;
                end else begin
                    next_cr.aux = cr.aux - 32'h1;
                end
            end
            SFESP_ASLEEP: begin
                if (frame_end && lk.op == OP_WAKE_ID && !lk.cnt[2]
                    && lk.cnt[2:0] == 3'h0 && (lk.cnt >= BITS_OPCODE || lk.ovf)) begin
                    next_cr.st = SFESP_WAKING;
                    next_cr.aux = (lk.cnt >= BITS_ID_END || lk.ovf) ?
                        32'(WAKE_ID_CYC) : 32'(WAKE_CYC);
                end
            end
            SFESP_WAKING: begin
                // everything is ignored until the device is awake again
                if (cr.aux <= 32'h1) begin
                    next_cr.st = SFESP_IDLE;
                    next_cr.sleep = 1'b0;
                end else begin
                    next_cr.aux = cr.aux - 32'h1;
                end
            end
            SFESP_IDLE: begin
                if (frame_end) begin
                    if (op_ok && lk.op == OP_WR_ENABLE) begin
                        next_cr.write_enable_latch = 1'b1;
                    end else if (op_ok && lk.op == OP_WR_DISABLE) begin
                        next_cr.write_enable_latch = 1'b0;
                    end else if (op_ok && lk.op == OP_SLEEP) begin
                        next_cr.st = SFESP_ENTERING;
                        next_cr.aux = 32'(SLEEP_CYC);
                    end else if (addr_ok && lk.op == OP_BLOCK_ERASE && cr.write_enable_latch
                                 && !blk_prot) begin
                        next_cr.st = SFESP_ERASE;
                        next_cr.busy = 1'b1;
                        next_cr.blk = tgt;
                        next_cr.tmr = 32'(ERASE_BLK_CYCLES);
                    end else if (op_ok && (lk.op == OP_CHIP_ERASE_A
                                 || lk.op == OP_CHIP_ERASE_B) && cr.write_enable_latch
                                 && !chip_prot) begin
                        next_cr.st = SFESP_ERASE;
                        next_cr.busy = 1'b1;
                        next_cr.chip = 1'b1;
                        next_cr.tmr = 32'(ERASE_ALL_CYCLES);
                    end
                end
            end
            default: begin
                next_cr.st = SFESP_IDLE;
            end
        endcase
    end

    // power loss is the reset: the pause flag and any pending work are lost
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cr <= '{st: SFESP_IDLE, tmr: 32'h0, aux: 32'h0, blk: 4'h0, cs_m: 1'b1,
                cs_s: 1'b1, cs_p: 1'b1, default: 1'b0};
        end else begin
            cr <= next_cr;
        end
    end

    // erase and program opcode decodes feed no logic; they are folded here only so they count as used
    logic unused_ok;
    assign unused_ok = is_erase_op | is_prog_op | lk.sh[31];

    assign busy_o = cr.busy;
    assign write_enable_latch_o = cr.write_enable_latch;
    assign paused_flag_o = cr.paused_flag;
    assign sleeping_o = cr.sleep;
    assign erase_chip_o = cr.chip;
    assign erase_block_o = cr.blk;
    assign erase_done_o = cr.done;

endmodule

`default_nettype wire

// File: sfesp_pkg.sv
// constants for the serial flash erase, pause and sleep sequencer
package sfesp_pkg;

    // opcodes
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_SECR_PROG = 8'h42;
    localparam logic [7:0] OP_SECR_ERASE = 8'h44;
    localparam logic [7:0] OP_HALF_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_PAUSE = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE_ID = 8'hab;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;

    // frame bit counts
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR_END = 6'h20;
    localparam logic [5:0] BITS_ID_END = 6'h28;
    localparam logic [5:0] BITS_WRAP_TOP = 6'h3f;
    localparam logic [4:0] OP_LAST_CNT = 5'h07;
    localparam logic [5:0] ADDR_LAST_CNT = 6'h1f;
    localparam logic [23:0] ID_ADDR = 24'h000000;

    // status byte presented on the serial output
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_SUS = 7;

    // protection decode
    localparam int BLK_MSB = 19;
    localparam int BLK_LSB = 16;
    localparam logic [3:0] BLK_TOP = 4'hf;
    localparam logic [3:0] BLK_BOTTOM = 4'h0;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_ALL_FROM = 3'h5;
    localparam logic [4:0] BLK_COUNT = 5'h10;

    // timing, figures in their own unit
    localparam int CLK_PERIOD_NS = 8;
    localparam int LARGE_BLOCK_ERASE_TIME_US = 150000;
    localparam int WHOLE_ARRAY_ERASE_TIME_MS = 2000;
    localparam int PAUSE_LATENCY_NS = 20000;
    localparam int SLEEP_ENTRY_TIME_NS = 3000;
    localparam int WAKE_TIME_NS = 3000;
    localparam int WAKE_WITH_ID_TIME_NS = 1800;

    // all times round down; pause, sleep and wake times never below one cycle
    localparam int ERASE_BLK_CYC = LARGE_BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_ALL_CYC = WHOLE_ARRAY_ERASE_TIME_MS / CLK_PERIOD_NS * 1000000;
    localparam int PAUSE_CYC = (PAUSE_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 :
        PAUSE_LATENCY_NS / CLK_PERIOD_NS;
    localparam int SLEEP_CYC = (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (WAKE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_ID_CYC = (WAKE_WITH_ID_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        WAKE_WITH_ID_TIME_NS / CLK_PERIOD_NS;

    // sequencer states, gray from idle through erase to paused and from entering through asleep to waking
    typedef enum logic [2:0] {
        SFESP_IDLE = 3'h0,
        SFESP_ERASE = 3'h1,
        SFESP_PAUSING = 3'h3,
        SFESP_PAUSED = 3'h2,
        SFESP_ENTERING = 3'h6,
        SFESP_ASLEEP = 3'h7,
        SFESP_WAKING = 3'h5
    } sfesp_state_t;

endpackage

// File: sfesp_monitor.sv
// assertion checker for the serial flash erase, pause and sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module sfesp_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // serial link
    input wire logic cs_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    // status
    input wire logic busy_o,
    input wire logic write_enable_latch_o,
    input wire logic paused_flag_o,
    input wire logic sleeping_o,
    input wire logic erase_chip_o,
    input wire logic erase_done_o
);
    localparam int PAUSE_MAX = 2500;
    localparam int RESUME_MAX = 25;
    logic [11:0] pause_cnt;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    // cycles paused with busy still high; too long to unroll as a delay range
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !(paused_flag_o && busy_o)) begin
            pause_cnt <= 12'h000;
        end else begin
            pause_cnt <= pause_cnt + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////
    // busy must hold at the pause, then drop inside the latency
    sequence s_pause_settle;
        busy_o ##1 (pause_cnt == 12'h001);
    endsequence
    sequence s_erase_end;
        !busy_o && !write_enable_latch_o;
    endsequence
    ////////////////////////////////////////////////////////////
    chk_pause_settle: assert property ($rose(paused_flag_o) |-> s_pause_settle)
        else $error("busy not held at pause");
    chk_pause_bound: assert property (pause_cnt <= 12'(PAUSE_MAX))
        else $error("pause did not settle within latency");
    chk_pause_needs_busy: assert property ($rose(paused_flag_o) |-> $past(busy_o))
        else $error("pause taken while idle");
    chk_resume_busy: assert property ($fell(paused_flag_o) |-> ##[0:RESUME_MAX] busy_o)
        else $error("busy not back after resume");
    chk_done_clears: assert property (erase_done_o |-> ##[0:1] s_erase_end)
        else $error("latch or busy left set after erase");
    chk_done_pulse: assert property (erase_done_o |=> !erase_done_o)
        else $error("done pulse longer than one cycle");
    chk_start_needs_latch: assert property (
        $rose(busy_o) && !$fell(paused_flag_o) |-> write_enable_latch_o)
        else $error("erase started without write enable");
    chk_chip_no_pause: assert property (erase_chip_o |-> !paused_flag_o)
        else $error("whole-array erase paused");
    chk_sleep_quiet: assert property (sleeping_o |-> !busy_o && !erase_chip_o)
        else $error("busy while asleep");
    chk_out_idle: assert property (cs_n_i && $past(cs_n_i) |-> so_oe_n_o && !so_o)
        else $error("serial output driven while deselected");
endmodule

bind sfesp_core sfesp_monitor mon_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .so_o(so_o),
    .so_oe_n_o(so_oe_n_o), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
    .paused_flag_o(paused_flag_o), .sleeping_o(sleeping_o), .erase_chip_o(erase_chip_o),
    .erase_done_o(erase_done_o));
`default_nettype wire

// File: sfesp_host.sv
// host controller model that clocks frames into the sequencer
`timescale 1ns/1ps
`default_nettype none
module sfesp_host (
    // link toward the device
    output logic link_clk_o,
    output logic cs_n_o,
    output logic serial_in_o,
    input wire logic so_i
);
    localparam time HALF = 40;
    initial begin
        link_clk_o = 1'b0;
        cs_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // clock stands low outside frames; data toggles so stale bits never look valid
    task automatic frame(input logic [63:0] bits, input int nbits, input int nrd,
                         output logic [15:0] rd);
        rd = 16'h0000;
        #13;
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits + nrd; i++) begin
            serial_in_o = (i < nbits) ? bits[nbits - 1 - i] : ~serial_in_o;
            #HALF link_clk_o = 1'b1;
            if (i >= nbits) begin
                rd = {rd[14:0], so_i};
            end
            #HALF link_clk_o = 1'b0;
        end
        #HALF cs_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
    endtask
endmodule
`default_nettype wire

// File: sfesp_core_tb.sv
// self-checking bench for the serial flash erase, pause and sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module sfesp_core_tb;
    import sfesp_pkg::*;
    localparam logic [7:0] MFR = 8'h5a; // arbitrary value
    localparam logic [7:0] DEV = 8'hc3; // arbitrary value
    logic core_clk_i;
    logic rst_i;
    logic link_clk, cs_n, sdi, so, so_oe_n, compl_prot, small_prot, top_sel;
    logic busy, wr_en, paused, sleeping, chip, done;
    logic [2:0] bp;
    logic [3:0] blk, blk_exp;
    logic [7:0] seed;
    logic [15:0] rd, fl;
    logic [15:0] exp_q[$];
    logic [15:0] got_q[$];
    logic [7:0] chip_ops[2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    int failures = 0;
    int comparisons = 0;
    assign fl = {7'h00, blk, chip, sleeping, paused, wr_en, busy};
    // released output line floats high through its pull-up
    logic so_line;
    assign so_line = so_oe_n ? 1'b1 : so;
    ////////////////////////////////////////////////////////////
    sfesp_core #(.ERASE_BLK_CYCLES(2000), .ERASE_ALL_CYCLES(1500), .MFR_ID(MFR), .DEV_ID(DEV))
    dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .cs_n_i(cs_n),
        .serial_in_i(sdi), .so_o(so), .so_oe_n_o(so_oe_n), .complement_protect_i(compl_prot),
        .small_unit_protect_i(small_prot), .top_bottom_select_i(top_sel),
        .block_protect_field_i(bp), .busy_o(busy), .write_enable_latch_o(wr_en),
        .paused_flag_o(paused), .sleeping_o(sleeping), .erase_chip_o(chip),
        .erase_block_o(blk), .erase_done_o(done));
    sfesp_host host_u (.link_clk_o(link_clk), .cs_n_o(cs_n), .serial_in_o(sdi), .so_i(so_line));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [15:0] ex(input logic [3:0] b, input logic [4:0] f);
        return {7'h00, b, f};
    endfunction
    task automatic note(input logic [15:0] e, input logic [15:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // frames end with a settle gap longer than decode plus the deselect minimum
    task automatic xfer(input logic [63:0] b, input int nb, input int nr);
        host_u.frame(b, nb, nr, rd);
        cyc(6);
    endtask
    task automatic op(input logic [7:0] o);
        xfer({56'h0, o}, 8, 0);
    endtask
    task automatic adr(input logic [7:0] o, input logic [23:0] a);
        xfer({32'h0, o, a}, 32, 0);
    endtask
    task automatic stop_test();
        cyc(2);
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            failures++;
            $display("Error at %0t: wait ran out, expected %h got %h", $time, 1'b0, busy);
            stop_test();
        end
    endtask
    task automatic pause_blk(input logic [3:0] b);
        op(OP_WR_ENABLE);
        adr(OP_BLOCK_ERASE, {4'h0, b, 16'h0000});
        op(OP_PAUSE);
        note(ex(b, 5'h07), fl);
        wait_idle(2600);
        note(ex(b, 5'h06), fl);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk_i) begin
        while (got_q.size() > 0) begin
            comparisons++;
            if (got_q[0] !== exp_q[0]) begin
                failures++;
                $display("Error at %0t: expected %h got %h", $time, exp_q[0], got_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    initial begin
        rst_i = 1'b0;
        compl_prot = 1'b0;
        small_prot = 1'b0;
        top_sel = 1'b0;
        bp = BP_NONE;
        seed = 8'h2a;
        // a clean edge after time zero, so the link side sees reset as well
        #1 rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(4);
        note(16'h0000, fl);
        adr(OP_BLOCK_ERASE, 24'h010000);
        note(16'h0000, fl);
        op(OP_WR_ENABLE);
        xfer({32'h0, OP_BLOCK_ERASE, 24'h010000} >> 1, 31, 0);
        note(ex(4'h0, 5'h02), fl);
        seed = lfsr(seed);
        blk_exp = seed[3:0];
        adr(OP_BLOCK_ERASE, {4'h0, blk_exp, 16'h0000});
        note(ex(blk_exp, 5'h03), fl);
        xfer({56'h0, OP_RD_STATUS}, 8, 8);
        note(16'h0003, rd);
        xfer({32'h0, OP_WAKE_ID, 24'h0}, 32, 16);
        note(16'hffff, rd);
        wait_idle(2100);
        note(ex(blk_exp, 5'h00), fl);
        $display("test block erase done");
        // protection: full field, then complement of an empty field
        bp = BP_ALL_FROM;
        op(OP_WR_ENABLE);
        adr(OP_BLOCK_ERASE, 24'h020000);
        op(OP_CHIP_ERASE_A);
        note(ex(blk_exp, 5'h02), fl);
        bp = BP_NONE;
        compl_prot = 1'b1;
        adr(OP_BLOCK_ERASE, 24'h020000);
        note(ex(blk_exp, 5'h02), fl);
        compl_prot = 1'b0;
        // small-unit top block, then the two bottom blocks
        small_prot = 1'b1;
        bp = 3'h1;
        adr(OP_BLOCK_ERASE, 24'h0f0000);
        note(ex(blk_exp, 5'h02), fl);
        small_prot = 1'b0;
        top_sel = 1'b1;
        bp = 3'h2;
        adr(OP_BLOCK_ERASE, 24'h010000);
        note(ex(blk_exp, 5'h02), fl);
        top_sel = 1'b0;
        bp = BP_NONE;
        foreach (chip_ops[i]) begin
            op(OP_WR_ENABLE);
            op(chip_ops[i]);
            op(OP_PAUSE);
            note(ex(blk_exp, 5'h13), fl);
            wait_idle(1700);
        end
        $display("test protect and chip erase done");
        seed = lfsr(seed);
        blk_exp = seed[3:0];
        pause_blk(blk_exp);
        xfer({56'h0, OP_RD_STATUS}, 8, 8);
        note(16'h0082, rd);
        adr(OP_BLOCK_ERASE, {4'h0, ~blk_exp, 16'h0000});
        op(OP_CHIP_ERASE_B);
        op(OP_PAUSE);
        note(ex(blk_exp, 5'h06), fl);
        op(OP_RESUME);
        note(ex(blk_exp, 5'h03), fl);
        // no further pause follows a resume here, so its spacing is kept
        wait_idle(2100);
        note(ex(blk_exp, 5'h00), fl);
        pause_blk(4'h3);
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(4);
        op(OP_RESUME);
        note(16'h0000, fl);
        $display("test pause and resume done");
        xfer({55'h0, OP_SLEEP, 1'b0}, 9, 0);
        cyc(380);
        note(16'h0000, fl);
        op(OP_SLEEP);
        cyc(380);
        note(ex(4'h0, 5'h08), fl);
        xfer({56'h0, OP_RD_STATUS}, 8, 8);
        note(16'h00ff, rd);
        op(OP_WR_ENABLE);
        note(ex(4'h0, 5'h08), fl);
        op(OP_WAKE_ID);
        cyc(380);
        note(16'h0000, fl);
        op(OP_SLEEP);
        cyc(380);
        xfer({32'h0, OP_WAKE_ID, 24'h0}, 32, 16);
        note({DEV, DEV}, rd);
        cyc(230);
        note(16'h0000, fl);
        xfer({32'h0, OP_MFR_DEV_ID, ID_ADDR}, 32, 16);
        note({MFR, DEV}, rd);
        xfer({32'h0, OP_MFR_DEV_ID, 24'h000001}, 32, 16);
        note(16'hffff, rd);
        $display("test sleep and id done");
        stop_test();
    end
endmodule
`default_nettype wire
